/* core/wdsec_device.sv */
// Purpose: Fixed watchdog, reset launch sequence and code lock gating
// Assumes: reset_pin and wake are synchronous to pclk
// Notes: Crystal time base is a one-cycle enable divided from pclk
// Behaviour
// - Firmware refreshes watchdog within 1.5 seconds
// - Overflow resets chip with wake-up defaults
// - Wait 4100 crystal cycles, launch at zero
// - Overflow sets nonvolatile overflow flag
// - Firmware clears overflow flag after reading
// - Reset pin clears overflow flag
// - Only wake low or debug enable stops watchdog; nothing stops oscillator; here chip reset (hold and launch wait) also holds watchdog
// - Debug port enable stops the watchdog
// - Writing kick bit restarts watchdog count
// - Watchdog held in reset while wake low
// - Locked: emulator may only globally erase
// - Firmware sets lock during preboot window
// - Lock stays until the next chip reset
// - First 32 cycles inhibit emulator, flag shown
// - After preboot emulator allowed, subject to lock
// - Every chip reset clears the lock
// - Lock bit accepts only writes of one
// - Locked: no external program code read
// - Locked: page zero page erase refused
// - Locked: page zero writes inhibited
module wdsec_device
	import wdsec_pkg::*;
#(
	parameter int unsigned XTAL_DIVIDE = XTAL_DIV,
	parameter int unsigned DOG_COUNT = DOG_TICKS,
	parameter int unsigned LAUNCH_COUNT = LAUNCH_TICKS,
	parameter int unsigned PREBOOT_COUNT = PREBOOT_CYCLES
)
(
	// Clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// Chip reset pin (high resets) and internal wake level
	input wire logic reset_pin,
	input wire logic wake,
	// Link to firmware and emulator
	wdsec_if.device link,
	// Chip side results
	output logic chip_rst_n,
	output logic wake_defaults,
	output logic launch,
	output logic flash_go,
	output wdsec_op_e flash_op,
	output logic flash_page0
);

	// Crystal enable divider
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic xtal_tick;
	// Watchdog count in crystal ticks
	logic [17:0] dog_q;
	logic [17:0] dog_d;
	logic dog_clear;
	logic dog_ovf;
	// Launch delay and preboot counters
	logic [15:0] seq_q;
	logic [15:0] seq_d;
	wdsec_state_e state_q;
	wdsec_state_e state_d;
	// Flags
	logic ovf_q;
	logic ovf_d;
	logic wdr_q;
	logic wdr_d;
	logic lock_q;
	logic lock_d;
	// Request answer
	logic ack_q;
	logic ok_q;
	logic go_q;
	wdsec_op_e op_q;
	logic pg0_q;
	// Decoded conditions
	logic running;
	logic dbg_ok;
	logic req_take;
	logic req_allow;

	// Crystal tick divider, free running, no control can stop it
	assign xtal_tick = (div_q == 16'(XTAL_DIVIDE - 1));
	assign div_d = xtal_tick ? 16'h0000 : div_q + 16'h0001;

	// Watchdog restarts on kick, wake low, debug enable or chip reset
	assign dog_clear = link.kick
		| ~wake
		| link.dbg_en
		| (state_q != ST_RUN && state_q != ST_PRE);
	// Overflow is one pclk wide, on the tick that reaches terminal count
	assign dog_ovf = ~dog_clear & xtal_tick
		& (dog_q == 18'(DOG_COUNT - 1));
	assign dog_d = dog_clear ? 18'h00000 :
		(xtal_tick ? dog_q + 18'h00001 : dog_q);

	// Overflow flag: set wins over firmware clear; pin clears it
	assign ovf_d = dog_ovf ? 1'b1 :
		(reset_pin ? 1'b0 :
		(link.ovf_clr ? 1'b0 : ovf_q));

	// Reset cause: overflow selects wake-up defaults, pin selects reset
	assign wdr_d = dog_ovf ? 1'b1 : (reset_pin ? 1'b0 : wdr_q);

	// Lock: cleared in chip reset, only a one can be written
	assign lock_d = (state_q == ST_HOLD || state_q == ST_WAIT) ? 1'b0 :
		((link.lock_wr & link.lock_val) ? 1'b1 : lock_q);

	// Chip sequence next state
	always_comb
	begin
		state_d = state_q;
		seq_d = seq_q;
		if (reset_pin || dog_ovf)
		begin
			// Both causes reset the chip alike
			state_d = ST_HOLD;
			seq_d = 16'h0000;
		end
		else
		begin
			unique case (state_q)
				ST_HOLD:
				begin
					// Release into the launch delay
					state_d = ST_WAIT;
					seq_d = 16'h0000;
				end
				ST_WAIT:
				begin
					// Count crystal cycles before launch
					if (xtal_tick)
					begin
						if (seq_q == 16'(LAUNCH_COUNT - 1))
						begin
							state_d = ST_PRE;
							seq_d = 16'h0000;
						end
						else
							seq_d = seq_q + 16'h0001;
					end
				end
				ST_PRE:
				begin
					// Preboot window in processor cycles
					if (seq_q == 16'(PREBOOT_COUNT - 1))
						state_d = ST_RUN;
					else
						seq_d = seq_q + 16'h0001;
				end
				ST_RUN:
				begin
					// Normal running
					state_d = ST_RUN;
				end
			endcase
		end
	end

	// Decoded chip status
	assign running = (state_q == ST_RUN);
	// Emulator usable only after preboot and with its port enabled
	assign dbg_ok = running & link.dbg_en;
	assign req_take = link.req_valid & ~ack_q;
	// Lock gating of flash requests
	assign req_allow = (state_q == ST_PRE || running)
		& op_permitted(link.req_src, link.req_op, link.req_page0,
		lock_q, dbg_ok);

	// Divider, watchdog and sequence registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= 16'h0000;
			dog_q <= 18'h00000;
			seq_q <= 16'h0000;
			state_q <= ST_HOLD;
		end
		else
		begin
			div_q <= div_d;
			dog_q <= dog_d;
			seq_q <= seq_d;
			state_q <= state_d;
		end
	end

	// Flag registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_q <= 1'b0;
			wdr_q <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			ovf_q <= ovf_d;
			wdr_q <= wdr_d;
			lock_q <= lock_d;
		end
	end

	// Request answer, one cycle after the request is taken
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_q <= 1'b0;
			ok_q <= 1'b0;
			go_q <= 1'b0;
			op_q <= OP_READ;
			pg0_q <= 1'b0;
		end
		else
		begin
			ack_q <= req_take;
			go_q <= req_take & req_allow;
			if (req_take)
			begin
				ok_q <= req_allow;
				op_q <= link.req_op;
				pg0_q <= link.req_page0;
			end
		end
	end

	// Link outputs
	assign link.req_ack = ack_q;
	assign link.req_ok = ok_q;
	assign link.ovf_flag = ovf_q;
	assign link.lock = lock_q;
	assign link.preboot = (state_q == ST_PRE);
	assign link.cpu_run = running;

	// Chip outputs
	assign chip_rst_n = (state_q == ST_PRE || running);
	assign wake_defaults = wdr_q;
	assign launch = (state_q == ST_WAIT) & (state_d == ST_PRE);
	assign flash_go = go_q;
	assign flash_op = op_q;
	assign flash_page0 = pg0_q;

endmodule // wdsec_device

/* core/wdsec_pkg.sv */
// Purpose: Shared constants and types for the watchdog and boot security
// Assumes: One clock, pclk at 200 MHz; crystal rate made by an enable
// Notes: Host register map is APB, one aligned 32-bit word per register
package wdsec_pkg;

	// Clock and crystal rates
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned XTAL_HZ = 32_768;
	// Crystal enable divider, pclk cycles per crystal cycle
	localparam int unsigned XTAL_DIV = CLK_HZ / XTAL_HZ;

	// Longest refresh interval in milliseconds, and crystal ticks
	localparam int unsigned DOG_PERIOD_MS = 1500;
	localparam int unsigned DOG_TICKS = (DOG_PERIOD_MS * XTAL_HZ) / 1000;
	// Launch delay after overflow in crystal cycles
	localparam int unsigned LAUNCH_TICKS = 4100;
	// Preboot length in processor cycles
	localparam int unsigned PREBOOT_CYCLES = 32;

	// Flash operation codes
	typedef enum logic [1:0]
	{
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_PAGE_ERASE = 2'h2,
		OP_GLOBAL_ERASE = 2'h3
	} wdsec_op_e;

	// Request source
	localparam logic SRC_CPU = 1'b0;
	localparam logic SRC_DBG = 1'b1;

	// Chip sequence states, Gray along hold, wait, preboot, run
	typedef enum logic [1:0]
	{
		ST_HOLD = 2'h0,
		ST_WAIT = 2'h1,
		ST_PRE = 2'h3,
		ST_RUN = 2'h2
	} wdsec_state_e;

	// Host register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_REQ = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;

	// CTRL fields (write)
	localparam int CTRL_KICK = 0;
	localparam int CTRL_OVF_CLR = 1;
	localparam int CTRL_LOCK_WR = 2;
	localparam int CTRL_LOCK_VAL = 3;
	localparam int CTRL_DBG_EN = 4;
	// REQ fields (write starts a request)
	localparam int REQ_OP_LO = 0;
	localparam int REQ_SRC = 2;
	localparam int REQ_PAGE0 = 3;
	// STATUS fields (read)
	localparam int ST_OVF = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_PREBOOT = 2;
	localparam int ST_CPU_RUN = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_LAST_OK = 5;
	localparam int ST_DBG_EN = 6;

	// Decide whether a flash request may proceed
	function automatic logic op_permitted(input logic src,
		input wdsec_op_e op, input logic page0, input logic lock,
		input logic dbg_ok);
		logic ok;
		ok = 1'b1;
		if (src == SRC_DBG && !dbg_ok)
			ok = 1'b0;
		if (lock && src == SRC_DBG && op != OP_GLOBAL_ERASE)
			ok = 1'b0;
		if (lock && page0 && (op == OP_PAGE_ERASE || op == OP_WRITE))
			ok = 1'b0;
		return ok;
	endfunction

endpackage

/* core/wdsec_if.sv */
// Purpose: Link between firmware/emulator end and the security device
// Assumes: Both ends on pclk; all signals synchronous
// Notes: Request holds until the device acknowledges for one cycle
interface wdsec_if;
	import wdsec_pkg::*;

	// Watchdog and lock orders from firmware
	logic kick;
	logic ovf_clr;
	logic lock_wr;
	logic lock_val;
	logic dbg_en;
	// Flash request and answer
	logic req_valid;
	logic req_src;
	wdsec_op_e req_op;
	logic req_page0;
	logic req_ack;
	logic req_ok;
	// Device status
	logic ovf_flag;
	logic lock;
	logic preboot;
	logic cpu_run;

	// Documented device end
	modport device (
		input kick, ovf_clr, lock_wr, lock_val, dbg_en,
		input req_valid, req_src, req_op, req_page0,
		output req_ack, req_ok,
		output ovf_flag, lock, preboot, cpu_run
	);

	// Firmware and emulator end
	modport host (
		output kick, ovf_clr, lock_wr, lock_val, dbg_en,
		output req_valid, req_src, req_op, req_page0,
		input req_ack, req_ok,
		input ovf_flag, lock, preboot, cpu_run
	);

endinterface

/* core/wdsec_host.sv */
// Purpose: Firmware and emulator end, ordered by software over APB
// Assumes: APB slave answers with no wait state
// Notes: CTRL bits are one-cycle orders except the lock value and debug enable levels
module wdsec_host
	import wdsec_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the device
	wdsec_if.host link
);

	// Decoded access
	logic acc;
	logic wr_ctrl;
	logic wr_req;
	logic rd_stat;
	logic mapped;
	// Order pulses and levels
	logic kick_q;
	logic clr_q;
	logic lwr_q;
	logic lval_q;
	logic dbg_q;
	// Request holding registers
	logic valid_q;
	logic src_q;
	wdsec_op_e op_q;
	logic pg0_q;
	logic last_ok_q;
	// Status word
	logic [31:0] stat_w;

	// Address decode
	assign acc = psel & penable;
	assign mapped = (paddr == REG_CTRL) | (paddr == REG_REQ)
		| (paddr == REG_STATUS);
	assign wr_ctrl = acc & pwrite & (paddr == REG_CTRL);
	// A request write while one is pending is dropped
	assign wr_req = acc & pwrite & (paddr == REG_REQ) & ~valid_q;
	assign rd_stat = acc & ~pwrite & (paddr == REG_STATUS);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// Status word assembly
	always_comb
	begin
		stat_w = 32'h0000_0000;
		stat_w[ST_OVF] = link.ovf_flag;
		stat_w[ST_LOCK] = link.lock;
		stat_w[ST_PREBOOT] = link.preboot;
		stat_w[ST_CPU_RUN] = link.cpu_run;
		stat_w[ST_BUSY] = valid_q;
		stat_w[ST_LAST_OK] = last_ok_q;
		stat_w[ST_DBG_EN] = dbg_q;
	end

	// Orders toward the device
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			kick_q <= 1'b0;
			clr_q <= 1'b0;
			lwr_q <= 1'b0;
			lval_q <= 1'b0;
			dbg_q <= 1'b0;
		end
		else
		begin
			kick_q <= wr_ctrl & pwdata[CTRL_KICK];
			clr_q <= wr_ctrl & pwdata[CTRL_OVF_CLR];
			lwr_q <= wr_ctrl & pwdata[CTRL_LOCK_WR];
			if (wr_ctrl)
			begin
				lval_q <= pwdata[CTRL_LOCK_VAL];
				dbg_q <= pwdata[CTRL_DBG_EN];
			end
		end
	end

	// Request held until acknowledged
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			valid_q <= 1'b0;
			src_q <= SRC_CPU;
			op_q <= OP_READ;
			pg0_q <= 1'b0;
			last_ok_q <= 1'b0;
		end
		else if (wr_req)
		begin
			valid_q <= 1'b1;
			src_q <= pwdata[REQ_SRC];
			op_q <= wdsec_op_e'(pwdata[REQ_OP_LO +: 2]);
			pg0_q <= pwdata[REQ_PAGE0];
		end
		else if (valid_q && link.req_ack)
		begin
			valid_q <= 1'b0;
			last_ok_q <= link.req_ok;
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= (paddr == REG_STATUS) ? stat_w : 32'h0000_0000;
		else if (rd_stat)
			prdata <= stat_w;
	end

	// Link drive
	assign link.kick = kick_q;
	assign link.ovf_clr = clr_q;
	assign link.lock_wr = lwr_q;
	assign link.lock_val = lval_q;
	assign link.dbg_en = dbg_q;
	assign link.req_valid = valid_q;
	assign link.req_src = src_q;
	assign link.req_op = op_q;
	assign link.req_page0 = pg0_q;

endmodule // wdsec_host

/* verification/wdsec_chk.sv */
// Purpose: Checks on the link between host and device ends
// Assumes: One clock domain, pclk
// Notes: PREBOOT_COUNT matches the device instance
module wdsec_chk
	import wdsec_pkg::*;
#(
	parameter int unsigned PREBOOT_COUNT = 32
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Orders from the host end
	input wire logic ovf_clr,
	input wire logic lock_wr,
	input wire logic lock_val,
	input wire logic dbg_en,
	// Flash request and answer
	input wire logic req_src,
	input wire wdsec_op_e req_op,
	input wire logic req_page0,
	input wire logic req_ack,
	input wire logic req_ok,
	// Device status
	input wire logic ovf_flag,
	input wire logic lock,
	input wire logic preboot,
	input wire logic cpu_run
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Chip held in reset
	wire in_rst = !preboot && !cpu_run;
	// Emulator request answered
	wire dbg_ack = req_ack && req_src == SRC_DBG;
	// Length of the current preboot run
	logic [7:0] pre_cnt_q;
	logic [7:0] pre_cnt_d;
	assign pre_cnt_d = preboot ? pre_cnt_q + 8'h01 : 8'h00;
	// Count preboot cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_cnt_q <= 8'h00;
		else
			pre_cnt_q <= pre_cnt_d;
	end
	lock_set_a: assert property
		(lock_wr && lock_val && !in_rst |=> lock)
		else $error("lock write of one not taken");
	lock_hold_a: assert property
		($fell(lock) |-> in_rst)
		else $error("lock dropped while chip running");
	lock_clr_a: assert property
		(in_rst [*2] |-> !lock)
		else $error("lock kept through chip reset");
	pre_len_a: assert property
		($rose(cpu_run) |-> pre_cnt_q == 8'(PREBOOT_COUNT))
		else $error("preboot length wrong");
	dbg_pre_a: assert property
		(dbg_ack && $past(preboot) |-> !req_ok)
		else $error("emulator served in preboot");
	dbg_lock_a: assert property
		(dbg_ack && $past(lock) && req_op != OP_GLOBAL_ERASE |-> !req_ok)
		else $error("locked emulator op served");
	page0_lock_a: assert property
		(req_ack && $past(lock) && req_page0
			&& req_op inside {OP_WRITE, OP_PAGE_ERASE} |-> !req_ok)
		else $error("locked page zero change served");
	dbg_run_a: assert property
		(dbg_ack && $past(cpu_run) && $past(dbg_en) && !$past(lock)
			|-> req_ok)
		else $error("unlocked emulator op refused");
	ovf_rst_a: assert property
		($rose(ovf_flag) |-> in_rst)
		else $error("overflow without chip reset");
	ovf_clr_a: assert property
		(ovf_clr && !in_rst |=> !ovf_flag || in_rst)
		else $error("overflow flag not cleared");
endmodule // wdsec_chk

/* verification/watchdog_and_boot_security_tb.sv */
// Purpose: Bench joining host and device ends over the link
// Assumes: Shortened crystal divider and counts
// Notes: Orders reach the host end over APB
module watchdog_and_boot_security_tb
	import wdsec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Shortened counts
	localparam int XD = 4;
	localparam int WC = 20;
	localparam int LC = 5;
	// Bench drive
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic reset_pin = 1'b0;
	logic wake = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	// Observed
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, chip_rst_n, wake_defaults, launch;
	logic flash_go, flash_page0;
	wdsec_op_e flash_op;
	logic [1:0] op;
	logic src, pg;
	int fail_count = 0;
	int compares = 0;
	int t;
	// Flash orders seen, and orders the rules permit
	int go_count = 0;
	int want_go = 0;
	wdsec_if link ();
	// Events the wait task watches
	wire [3:0] ev = {link.cpu_run, link.preboot, launch, link.ovf_flag};
	wdsec_device #(.XTAL_DIVIDE(XD), .DOG_COUNT(WC), .LAUNCH_COUNT(LC))
		wdsec_device_i (.pclk, .presetn, .reset_pin, .wake, .link(link),
		.chip_rst_n, .wake_defaults, .launch, .flash_go, .flash_op,
		.flash_page0);
	wdsec_host wdsec_host_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
	wdsec_chk #(.PREBOOT_COUNT(32)) wdsec_chk_i (.pclk, .presetn,
		.ovf_clr(link.ovf_clr), .lock_wr(link.lock_wr),
		.lock_val(link.lock_val), .dbg_en(link.dbg_en),
		.req_src(link.req_src), .req_op(link.req_op),
		.req_page0(link.req_page0), .req_ack(link.req_ack),
		.req_ok(link.req_ok), .ovf_flag(link.ovf_flag), .lock(link.lock),
		.preboot(link.preboot), .cpu_run(link.cpu_run));
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	// Count flash orders issued by the device
	always @(posedge pclk)
		if (flash_go)
			go_count <= go_count + 1;
	// Compare one bit
	task automatic chk(input logic s, input logic e);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("FAIL %0t: got %b want %b", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One APB transfer; data and error taken at the edge ending access
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic st();
		apb(1'b0, REG_STATUS, 32'h0);
	endtask
	// Issue a flash request and poll until it is answered
	task automatic req(input logic [1:0] o, input logic s, input logic p);
		int i;
		apb(1'b1, REG_REQ, {28'h0, p, s, o});
		repeat (2) @(posedge pclk);
		i = 0;
		do
		begin
			st();
			i++;
		end
		while (rd[ST_BUSY] !== 1'b0 && i < 10);
	endtask
	// Wait for event k, cycles in t; a run-out counts as a mismatch
	task automatic wait_ev(input int k, input int lim);
		t = 0;
		@(negedge pclk);
		while (ev[k] !== 1'b1 && t < lim)
		begin
			@(negedge pclk);
			t++;
		end
		if (t >= lim)
			fail_count++;
		@(posedge pclk);
	endtask
	// Answer expected while locked with emulator enabled
	function automatic logic want(input logic [1:0] o, input logic s,
		input logic p);
		if (s && o != 2'h3)
			return 1'b0;
		return !(p && (o == 2'h1 || o == 2'h2));
	endfunction
	// Main sequence
	initial
	begin
		t = $urandom(32'hf95bbd80);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_ev(2, 100);
		// Preboot: emulator enabled, lock still clear, must be refused
		apb(1'b1, REG_CTRL, 32'h10);
		st();
		chk(rd[ST_PREBOOT], 1'b1);
		req(2'h0, SRC_DBG, 1'b0);
		chk(rd[ST_LAST_OK], 1'b0);
		// Lock set while preboot still runs
		apb(1'b1, REG_CTRL, 32'h1c);
		wait_ev(3, 100);
		// Lock write of zero leaves the lock set
		apb(1'b1, REG_CTRL, 32'h14);
		st();
		chk(rd[ST_LOCK], 1'b1);
		// Every code from both sources on page zero, then random
		for (int i = 0; i < 20; i++)
		begin
			op = i < 8 ? 2'(i) : 2'($urandom);
			src = i < 8 ? i[2] : 1'($urandom);
			pg = i < 8 ? 1'b1 : 1'($urandom);
			req(op, src, pg);
			want_go += want(op, src, pg);
			chk(rd[ST_LAST_OK], want(op, src, pg));
			chk(flash_op == wdsec_op_e'(op) && flash_page0 == pg, 1'b1);
		end
		chk(go_count == want_go, 1'b1);
		chk(link.ovf_flag, 1'b0);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (6)
		begin
			apb(1'b1, REG_CTRL, 32'h1);
			repeat (60) @(posedge pclk);
		end
		chk(link.ovf_flag, 1'b0);
		apb(1'b1, REG_CTRL, 32'h1);
		wait_ev(0, 200);
		chk(t inside {[70:84]}, 1'b1);
		chk(wake_defaults, 1'b1);
		wait_ev(1, 200);
		chk(t inside {[18:60]}, 1'b1);
		st();
		chk(rd[ST_LOCK], 1'b0);
		chk(rd[ST_OVF], 1'b1);
		apb(1'b1, REG_CTRL, 32'h2);
		st();
		chk(rd[ST_OVF], 1'b0);
		apb(1'b1, 12'hffc, 32'h10);
		chk(err, 1'b1);
		chk(link.dbg_en, 1'b0);
		wake <= 1'b0;
		repeat (200) @(posedge pclk);
		chk(link.ovf_flag, 1'b0);
		wake <= 1'b1;
		wait_ev(0, 200);
		reset_pin <= 1'b1;
		@(posedge pclk);
		reset_pin <= 1'b0;
		@(posedge pclk);
		chk(link.ovf_flag, 1'b0);
		chk(chip_rst_n, 1'b0);
		chk(wake_defaults, 1'b0);
		wait_ev(3, 200);
		apb(1'b1, REG_CTRL, 32'h10);
		req(2'h1, SRC_DBG, 1'b1);
		chk(rd[ST_LAST_OK], 1'b1);
		chk(rd[ST_CPU_RUN] & rd[ST_DBG_EN], 1'b1);
		report_and_stop();
	end
	// Hang guard
	initial
	begin
		#40us;
		fail_count++;
		report_and_stop();
	end
endmodule // watchdog_and_boot_security_tb
